// ### design/fep_dev.sv
// Flash controller end: array, protection, operation timing, interrupt sources
`timescale 1ns/1ps
`include "fep_cfg.svh"
// Notes on behaviour
// - Erase fills one 1 kB block with 0xFF
// - Protected blocks are never erased
// - Requester waits for erase completion
// - Erase fails on bad address or protection
// - Program stores new AND old word
// - Program address word aligned, one word each
// - Requester waits, verifies programmed data itself
// - Two sources, done and bad access, clearable
// - Only enabled sources reach the interrupt
// - Raw and masked status both readable
// - Software clears sources early in handler
// - One of three levels per 2 kB
// - Open allows all; no-write read and fetch
// - Fetch-only refuses data reads
// - Commit makes protection survive i_rst; power-on clears it
// - Protection change fails on bad address/level
// - Protection only tightens, never loosens
// - Clocks per microsecond time erase, program
// - Disallowed access raises bad access source
// - Finished erase or program raises done
module fep_dev #(
	parameter int FLASH_KB = 4,
	parameter int ERASE_US = `FEP_ERASE_US,
	parameter int PROG_US = `FEP_PROG_US
)(
	// Clocks and resets; i_nv_rst models power-on of the nonvolatile cells
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_nv_rst,
	// Link to host end
	fep_if.dev bus,
	// Processor interrupt
	output logic o_irq
);
	localparam int WPK = `FEP_ERASE_BYTES / 4;
	localparam int WORDS = FLASH_KB * WPK;
	localparam int PBLK = FLASH_KB * `FEP_ERASE_BYTES / `FEP_PROT_BYTES;
	localparam int AW = $clog2(WORDS);
	localparam logic [31:0] SIZE = 32'(FLASH_KB * `FEP_ERASE_BYTES);
	localparam logic [15:0] ERASE_CNT = 16'(ERASE_US);
	localparam logic [15:0] PROG_CNT = 16'(PROG_US);

	typedef enum logic [1:0] {
		st_load,
		st_idle,
		st_busy
	} fep_st_e;

	function automatic logic in_range(input logic [31:0] a);
		return a < SIZE;
	endfunction

	function automatic int pblk(input logic [31:0] a);
		return int'(a / `FEP_PROT_BYTES);
	endfunction

	function automatic int widx(input logic [31:0] a);
		return int'(a[AW+1:2]);
	endfunction

	// Nonvolatile state: survives i_rst, cleared only by power-on
	logic [31:0] mem_r [WORDS];
	logic [31:0] mem_nxt [WORDS];
	logic [1:0] nv_prot_r [PBLK];
	logic [1:0] nv_prot_nxt [PBLK];
	// Working state
	logic [1:0] prot_r [PBLK];
	logic [1:0] prot_nxt [PBLK];
	fep_st_e state_r, state_nxt;
	logic [2:0] op_r, op_nxt;
	logic [31:0] addr_r, addr_nxt, data_r, data_nxt;
	logic [7:0] div_r, div_nxt;
	logic [15:0] us_r, us_nxt;
	logic done_r, done_nxt, ok_r, ok_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] flag_r, flag_nxt;
	logic set_done, set_bad, rng, tick;
	logic [1:0] lvl;

	always_comb
	begin
		state_nxt = state_r;
		prot_nxt = prot_r;
		nv_prot_nxt = nv_prot_r;
		mem_nxt = mem_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		div_nxt = div_r;
		us_nxt = us_r;
		done_nxt = 1'b0;
		ok_nxt = ok_r;
		rdata_nxt = rdata_r;
		set_done = 1'b0;
		set_bad = 1'b0;
		rng = in_range(bus.req_addr);
		lvl = rng ? prot_r[pblk(bus.req_addr)] : 2'h0;
		// Zero is taken as one clock per microsecond
		tick = (div_r + 8'h01 >= bus.usec);
		case (state_r)
		st_load:
		begin
			// Committed levels come back after every chip reset
			prot_nxt = nv_prot_r;
			state_nxt = st_idle;
		end
		st_idle:
			if (bus.req_valid)
			begin
				done_nxt = 1'b1;
				ok_nxt = 1'b0;
				rdata_nxt = 32'h0;
				case (bus.req_cmd)
				3'(fep_pkg::fep_cmd_read):
					if (rng && lvl == 2'(fep_pkg::prot_level_fetch_only))
						set_bad = 1'b1;
					else if (rng)
					begin
						ok_nxt = 1'b1;
						rdata_nxt = mem_r[widx(bus.req_addr)];
					end
				3'(fep_pkg::fep_cmd_fetch):
					if (rng)
					begin
						ok_nxt = 1'b1;
						rdata_nxt = mem_r[widx(bus.req_addr)];
					end
				3'(fep_pkg::fep_cmd_erase),
				3'(fep_pkg::fep_cmd_program):
					if (!rng)
						ok_nxt = 1'b0;
					else if (bus.req_cmd == 3'(fep_pkg::fep_cmd_erase)
						&& bus.req_addr[9:0] != 10'h0)
						ok_nxt = 1'b0;
					else if (bus.req_addr[1:0] != 2'h0)
						ok_nxt = 1'b0;
					else if (lvl != 2'(fep_pkg::prot_level_open))
						set_bad = 1'b1;
					else
					begin
						done_nxt = 1'b0;
						ok_nxt = ok_r;
						rdata_nxt = rdata_r;
						op_nxt = bus.req_cmd;
						addr_nxt = bus.req_addr;
						data_nxt = bus.req_wdata;
						div_nxt = 8'h0;
						us_nxt = (bus.req_cmd == 3'(fep_pkg::fep_cmd_erase))
							? ERASE_CNT : PROG_CNT;
						state_nxt = st_busy;
					end
				3'(fep_pkg::fep_cmd_prot_set):
					if (!rng || bus.req_addr[10:0] != 11'h0 || bus.req_prot == 2'h3)
						ok_nxt = 1'b0;
					else if (bus.req_prot < lvl)
						ok_nxt = 1'b0;
					else
					begin
						prot_nxt[pblk(bus.req_addr)] = bus.req_prot;
						ok_nxt = 1'b1;
					end
				3'(fep_pkg::fep_cmd_prot_get):
					if (rng)
					begin
						ok_nxt = 1'b1;
						rdata_nxt = {30'h0, lvl};
					end
				3'(fep_pkg::fep_cmd_commit):
				begin
					nv_prot_nxt = prot_r;
					ok_nxt = 1'b1;
				end
				default: ok_nxt = 1'b0;
				endcase
			end
		st_busy:
		begin
			div_nxt = tick ? 8'h0 : div_r + 8'h01;
			if (tick)
			begin
				us_nxt = us_r - 16'h0001;
				if (us_r <= 16'h0001)
				begin
					if (op_r == 3'(fep_pkg::fep_cmd_erase))
						for (int i = 0; i < WPK; i++)
							mem_nxt[widx(addr_r) + i] = `FEP_ERASED_WORD;
					else
						mem_nxt[widx(addr_r)] = mem_r[widx(addr_r)] & data_r;
					done_nxt = 1'b1;
					ok_nxt = 1'b1;
					set_done = 1'b1;
					state_nxt = st_idle;
				end
			end
		end
		default: state_nxt = st_idle;
		endcase
		// A new event in the clearing cycle wins over the clear
		flag_nxt = (flag_r & ~bus.int_clr);
		flag_nxt[`FEP_INT_DONE] = flag_nxt[`FEP_INT_DONE] | set_done;
		flag_nxt[`FEP_INT_BAD] = flag_nxt[`FEP_INT_BAD] | set_bad;
	end

	always_ff @(posedge i_clk or posedge i_nv_rst)
	begin
		if (i_nv_rst)
		begin
			for (int i = 0; i < WORDS; i++)
				mem_r[i] <= `FEP_ERASED_WORD;
			for (int i = 0; i < PBLK; i++)
				nv_prot_r[i] <= 2'h0;
		end
		else
		begin
			mem_r <= mem_nxt;
			nv_prot_r <= nv_prot_nxt;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < PBLK; i++)
				prot_r[i] <= 2'h0;
			state_r <= st_load;
			op_r <= 3'h0;
			addr_r <= 32'h0;
			data_r <= 32'h0;
			div_r <= 8'h0;
			us_r <= 16'h0;
			done_r <= 1'b0;
			ok_r <= 1'b0;
			rdata_r <= 32'h0;
			flag_r <= 2'h0;
		end
		else
		begin
			prot_r <= prot_nxt;
			state_r <= state_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			div_r <= div_nxt;
			us_r <= us_nxt;
			done_r <= done_nxt;
			ok_r <= ok_nxt;
			rdata_r <= rdata_nxt;
			flag_r <= flag_nxt;
		end
	end

	assign bus.req_ready = (state_r == st_idle);
	assign bus.rsp_done = done_r;
	assign bus.rsp_ok = ok_r;
	assign bus.rsp_rdata = rdata_r;
	assign bus.int_raw = flag_r;
	assign bus.int_masked = flag_r & bus.int_en;
	assign o_irq = |(flag_r & bus.int_en);
endmodule

// ### design/fep_cfg.svh
// Offsets, field positions, reset values and timing figures of the flash block
`ifndef FEP_CFG_SVH
`define FEP_CFG_SVH

// Flash geometry in bytes
`define FEP_ERASE_BYTES 1024
`define FEP_PROT_BYTES 2048
`define FEP_ERASED_WORD 32'hFFFF_FFFF

// Operation times in microseconds
`define FEP_ERASE_US 20
`define FEP_PROG_US 2

// Clock rate, giving the reset value of clocks per microsecond
`define FEP_CLK_MHZ 40
`define FEP_USEC_RST 8'h28

// Interrupt source bit positions
`define FEP_INT_DONE 0
`define FEP_INT_BAD 1

// Host register byte offsets
`define FEP_REG_ADDR 8'h00
`define FEP_REG_WDATA 8'h04
`define FEP_REG_CMD 8'h08
`define FEP_REG_STATUS 8'h0C
`define FEP_REG_RDATA 8'h10
`define FEP_REG_USEC 8'h14
`define FEP_REG_INT_EN 8'h18
`define FEP_REG_INT_RAW 8'h1C
`define FEP_REG_INT_MSK 8'h20

// Field positions
`define FEP_CMD_LSB 0
`define FEP_PROT_LSB 4
`define FEP_STAT_BUSY 0
`define FEP_STAT_OK 1

`endif

// ### design/fep_pkg.sv
// Types shared by both ends of the flash block
package fep_pkg;

	typedef enum logic [2:0] {
		fep_cmd_read,
		fep_cmd_fetch,
		fep_cmd_erase,
		fep_cmd_program,
		fep_cmd_prot_set,
		fep_cmd_prot_get,
		fep_cmd_commit
	} fep_cmd_e;

	typedef enum logic [1:0] {
		prot_level_open,
		prot_level_no_write,
		prot_level_fetch_only
	} fep_prot_e;

endpackage

// ### design/fep_if.sv
// Link between the host register end and the flash controller end
`timescale 1ns/1ps
interface fep_if;
	logic req_valid;
	logic req_ready;
	logic [2:0] req_cmd;
	logic [31:0] req_addr;
	logic [31:0] req_wdata;
	logic [1:0] req_prot;
	logic rsp_done;
	logic rsp_ok;
	logic [31:0] rsp_rdata;
	logic [7:0] usec;
	logic [1:0] int_en;
	logic [1:0] int_clr;
	logic [1:0] int_raw;
	logic [1:0] int_masked;

	modport dev (
		input req_valid, req_cmd, req_addr, req_wdata, req_prot, usec, int_en, int_clr,
		output req_ready, rsp_done, rsp_ok, rsp_rdata, int_raw, int_masked
	);
	modport host (
		output req_valid, req_cmd, req_addr, req_wdata, req_prot, usec, int_en, int_clr,
		input req_ready, rsp_done, rsp_ok, rsp_rdata, int_raw, int_masked
	);
endinterface

// ### design/fep_host.sv
// Host end: APB register slave that issues flash requests over the link
`timescale 1ns/1ps
`include "fep_cfg.svh"
module fep_host (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Link to flash controller
	fep_if.host bus
);
	logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [2:0] cmd_r, cmd_nxt;
	logic [1:0] prot_r, prot_nxt, en_r, en_nxt, clr_r, clr_nxt;
	logic [7:0] usec_r, usec_nxt;
	logic pend_r, pend_nxt, busy_r, busy_nxt, ok_r, ok_nxt, err_r, err_nxt;
	logic setup, access;
	logic [7:0] off;

	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable;
	assign off = i_paddr[7:0];

	always_comb
	begin
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		cmd_nxt = cmd_r;
		prot_nxt = prot_r;
		usec_nxt = usec_r;
		en_nxt = en_r;
		clr_nxt = 2'h0;
		pend_nxt = pend_r;
		busy_nxt = busy_r;
		ok_nxt = ok_r;
		rdata_nxt = rdata_r;
		prdata_nxt = prdata_r;
		err_nxt = err_r;
		if (pend_r && bus.req_ready)
			pend_nxt = 1'b0;
		if (bus.rsp_done)
		begin
			busy_nxt = 1'b0;
			ok_nxt = bus.rsp_ok;
			rdata_nxt = bus.rsp_rdata;
		end
		// Data and error latched in setup so the access cycle answers from flops
		if (setup)
		begin
			err_nxt = 1'b0;
			prdata_nxt = 32'h0;
			if (i_paddr[31:8] != 24'h0 || i_paddr[1:0] != 2'h0)
				err_nxt = 1'b1;
			else
				case (off)
				`FEP_REG_ADDR: prdata_nxt = addr_r;
				`FEP_REG_WDATA: prdata_nxt = wdata_r;
				`FEP_REG_CMD:
					// Busy refuses a new command; misaligned program is never sent
					err_nxt = i_pwrite && (busy_r || (i_pwdata[2:0] == 3'(fep_pkg::fep_cmd_program)
						&& addr_r[1:0] != 2'h0));
				`FEP_REG_STATUS: prdata_nxt = {30'h0, ok_r, busy_r};
				`FEP_REG_RDATA: prdata_nxt = rdata_r;
				`FEP_REG_USEC: prdata_nxt = {24'h0, usec_r};
				`FEP_REG_INT_EN: prdata_nxt = {30'h0, en_r};
				`FEP_REG_INT_RAW: prdata_nxt = {30'h0, bus.int_raw};
				`FEP_REG_INT_MSK: prdata_nxt = {30'h0, bus.int_masked};
				default: err_nxt = 1'b1;
				endcase
		end
		if (access && i_pwrite && !err_r)
			case (off)
			`FEP_REG_ADDR: addr_nxt = i_pwdata;
			`FEP_REG_WDATA: wdata_nxt = i_pwdata;
			`FEP_REG_CMD:
			begin
				cmd_nxt = i_pwdata[`FEP_CMD_LSB +: 3];
				prot_nxt = i_pwdata[`FEP_PROT_LSB +: 2];
				pend_nxt = 1'b1;
				busy_nxt = 1'b1;
			end
			`FEP_REG_USEC: usec_nxt = i_pwdata[7:0];
			`FEP_REG_INT_EN: en_nxt = i_pwdata[1:0];
			`FEP_REG_INT_RAW: clr_nxt = i_pwdata[1:0];
			default: ;
			endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			addr_r <= 32'h0;
			wdata_r <= 32'h0;
			cmd_r <= 3'h0;
			prot_r <= 2'h0;
			usec_r <= `FEP_USEC_RST;
			en_r <= 2'h0;
			clr_r <= 2'h0;
			pend_r <= 1'b0;
			busy_r <= 1'b0;
			ok_r <= 1'b0;
			rdata_r <= 32'h0;
			prdata_r <= 32'h0;
			err_r <= 1'b0;
		end
		else
		begin
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			cmd_r <= cmd_nxt;
			prot_r <= prot_nxt;
			usec_r <= usec_nxt;
			en_r <= en_nxt;
			clr_r <= clr_nxt;
			pend_r <= pend_nxt;
			busy_r <= busy_nxt;
			ok_r <= ok_nxt;
			rdata_r <= rdata_nxt;
			prdata_r <= prdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign o_pready = access;
	assign o_prdata = prdata_r;
	assign o_pslverr = access && err_r;
	assign bus.req_valid = pend_r;
	assign bus.req_cmd = cmd_r;
	assign bus.req_addr = addr_r;
	assign bus.req_wdata = wdata_r;
	assign bus.req_prot = prot_r;
	assign bus.usec = usec_r;
	assign bus.int_en = en_r;
	assign bus.int_clr = clr_r;
endmodule

// ### verification/fep_link_props.sv
// Timing and flag checks on the link between the two flash ends
`timescale 1ns/1ps
module fep_link_props #(
	parameter int ERASE_US = 20,
	parameter int PROG_US = 2
)(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link signals
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [2:0] req_cmd,
	input wire logic [7:0] usec,
	input wire logic [1:0] int_en,
	input wire logic [1:0] int_clr,
	input wire logic rsp_done,
	input wire logic rsp_ok,
	input wire logic [31:0] rsp_rdata,
	input wire logic [1:0] int_raw,
	input wire logic [1:0] int_masked
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [2:0] op_r;
	logic [2:0] op_nxt;
	logic [15:0] us;

	// Zero clocks per microsecond is treated as one
	assign us = (usec == 8'h0) ? 16'h1 : {8'h0, usec};

	always_comb
	begin
		cnt_nxt = cnt_r + 16'h1;
		op_nxt = op_r;
		if (req_valid && req_ready)
		begin
			cnt_nxt = 16'h1;
			op_nxt = req_cmd;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_r <= 16'h0;
			op_r <= 3'h0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			op_r <= op_nxt;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_quick;
		s_take ##0 !(req_cmd inside {3'h2, 3'h3});
	endsequence

	chk_quick_answer: assert property (s_quick |=> rsp_done)
		else $error("short request not answered next cycle");
	chk_busy_refuse: assert property (s_take ##1 !rsp_done |-> !req_ready)
		else $error("ready while a request is in progress");
	chk_valid_drop: assert property (s_take |=> !req_valid)
		else $error("request still pending after it was taken");
	chk_erase_time: assert property (rsp_done && op_r == 3'h2 |->
		(cnt_r == 16'h1 && !rsp_ok) || (rsp_ok && cnt_r == ERASE_US * us + 1))
		else $error("erase answer at wrong time");
	chk_prog_time: assert property (rsp_done && op_r == 3'h3 |->
		(cnt_r == 16'h1 && !rsp_ok) || (rsp_ok && cnt_r == PROG_US * us + 1))
		else $error("program answer at wrong time");
	chk_done_flag: assert property ($rose(int_raw[0]) |->
		rsp_done && rsp_ok && op_r inside {3'h2, 3'h3})
		else $error("done flag without finished operation");
	chk_bad_flag: assert property ($rose(int_raw[1]) |-> rsp_done && !rsp_ok)
		else $error("bad access flag without refused request");
	chk_done_clear: assert property (int_clr[0] |=> !int_raw[0] || rsp_done)
		else $error("done flag survives clear");
	chk_bad_clear: assert property (int_clr[1] |=> !int_raw[1] || rsp_done)
		else $error("bad access flag survives clear");
	chk_mask_view: assert property (int_masked == (int_raw & int_en))
		else $error("masked status differs from raw and enables");
	chk_result_holds: assert property (!rsp_done |-> $stable(rsp_ok) && $stable(rsp_rdata))
		else $error("response changed without a new answer");
	chk_done_pulse: assert property (rsp_done |=> !rsp_done)
		else $error("done pulse longer than one cycle");
endmodule

// ### verification/onchip_flash_erase_program_protect_tb.sv
// Register-level test of the host and controller ends joined together
`timescale 1ns/1ps
module onchip_flash_erase_program_protect_tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_nv_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] q;
	logic [31:0] st;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int n_tests = 0;

	always #12.5 i_clk = ~i_clk;

	fep_if bus();
	fep_host fep_host_inst(.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .bus(bus));
	fep_dev #(.FLASH_KB(4)) fep_dev_inst(.i_clk(i_clk), .i_rst(i_rst), .i_nv_rst(i_nv_rst),
		.bus(bus), .o_irq(irq));
	fep_link_props #(.ERASE_US(20), .PROG_US(2)) fep_link_props_inst(.i_clk(i_clk),
		.i_rst(i_rst), .req_valid(bus.req_valid), .req_ready(bus.req_ready),
		.req_cmd(bus.req_cmd), .usec(bus.usec), .int_en(bus.int_en), .int_clr(bus.int_clr),
		.rsp_done(bus.rsp_done), .rsp_ok(bus.rsp_ok), .rsp_rdata(bus.rsp_rdata),
		.int_raw(bus.int_raw), .int_masked(bus.int_masked));

	task close_out;
		$display("Checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	task okc(input string nm, input logic e);
		chk(nm, {31'h0, st[1]}, {31'h0, e});
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge i_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			num_errors++;
			close_out();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Busy is polled since erase length follows the clocks per microsecond
	task wt;
		int k;
		k = 0;
		do
		begin
			apb(1'b0, 8'h0C, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 400);
		if (q[0] !== 1'b0)
		begin
			num_errors++;
			close_out();
		end
		st = q;
		apb(1'b0, 8'h10, 32'h0);
		rd = q;
	endtask

	task op(input logic [2:0] c, input logic [31:0] a, input logic [31:0] d, input logic [1:0] l);
		apb(1'b1, 8'h00, a);
		apb(1'b1, 8'h04, d);
		apb(1'b1, 8'h08, {26'h0, l, 1'b0, c});
		wt();
	endtask

	initial
	begin
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		i_nv_rst <= 1'b0;
		apb(1'b0, 8'h14, 32'h0);
		chk("usec reset", q, 32'h28);
		apb(1'b1, 8'h14, 32'h1);
		op(3'h3, 32'h3FC, 32'h12345678, 2'h0);
		op(3'h2, 32'h0, 32'h0, 2'h0);
		okc("erase ok", 1'h1);
		op(3'h0, 32'h3FC, 32'h0, 2'h0);
		chk("erased word", rd, `FEP_ERASED_WORD);
		apb(1'b0, 8'h1C, 32'h0);
		chk("done raw", q, 32'h1);
		op(3'h3, 32'h4, 32'hA5A5F0F0, 2'h0);
		op(3'h3, 32'h4, 32'h0F0FFFFF, 2'h0);
		op(3'h0, 32'h4, 32'h0, 2'h0);
		chk("and program", rd, 32'h0505F0F0);
		apb(1'b1, 8'h00, 32'h6);
		apb(1'b1, 8'h08, 32'h3);
		chk("misaligned program", {31'h0, err}, 32'h1);
		apb(1'b1, 8'h00, 32'h400);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h08, 32'h0);
		chk("command while busy", {31'h0, err}, 32'h1);
		wt();
		okc("second erase", 1'h1);
		apb(1'b1, 8'h18, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk("masked on", q, 32'h1);
		chk("irq on", {31'h0, irq}, 32'h1);
		apb(1'b1, 8'h18, 32'h2);
		apb(1'b0, 8'h20, 32'h0);
		chk("masked off", q, 32'h0);
		chk("irq off", {31'h0, irq}, 32'h0);
		apb(1'b1, 8'h1C, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk("cleared", q, 32'h0);
		op(3'h4, 32'h800, 32'h0, 2'h1);
		okc("set no write", 1'h1);
		op(3'h5, 32'h800, 32'h0, 2'h0);
		chk("get level", {30'h0, rd[1:0]}, 32'h1);
		op(3'h4, 32'h800, 32'h0, 2'h0);
		okc("loosen", 1'h0);
		op(3'h4, 32'h800, 32'h0, 2'h3);
		okc("bad level", 1'h0);
		op(3'h4, 32'h400, 32'h0, 2'h1);
		okc("bad block", 1'h0);
		op(3'h2, 32'hC00, 32'h0, 2'h0);
		okc("erase no write", 1'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk("bad raw", q, 32'h2);
		op(3'h3, 32'h800, 32'h0, 2'h0);
		okc("program no write", 1'h0);
		op(3'h0, 32'h800, 32'h0, 2'h0);
		chk("no write kept", rd, `FEP_ERASED_WORD);
		op(3'h4, 32'h800, 32'h0, 2'h2);
		okc("set fetch only", 1'h1);
		op(3'h0, 32'h800, 32'h0, 2'h0);
		okc("read fetch only", 1'h0);
		op(3'h1, 32'h800, 32'h0, 2'h0);
		chk("fetch", rd, `FEP_ERASED_WORD);
		op(3'h4, 32'h800, 32'h0, 2'h1);
		okc("fetch only fixed", 1'h0);
		op(3'h2, 32'h1000, 32'h0, 2'h0);
		okc("erase range", 1'h0);
		apb(1'b1, 8'h24, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		op(3'h7, 32'h0, 32'h0, 2'h0);
		okc("unknown command", 1'h0);
		op(3'h6, 32'h0, 32'h0, 2'h0);
		okc("commit", 1'h1);
		i_rst <= 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		op(3'h5, 32'h800, 32'h0, 2'h0);
		chk("level kept", {30'h0, rd[1:0]}, 32'h2);
		op(3'h0, 32'h4, 32'h0, 2'h0);
		chk("array kept", rd, 32'h0505F0F0);
		op(3'h3, 32'h8, 32'h0000FFFF, 2'h0);
		okc("slow program", 1'h1);
		op(3'h0, 32'h8, 32'h0, 2'h0);
		chk("slow program word", rd, 32'h0000FFFF);
		close_out();
	end
endmodule
